// [bench/mio_drive_model.sv]
/*
 * Servo drives on the motion network: each axis decodes its own pins
 * through shared selector codes. Assumes pins change just after an edge.
 */
`timescale 1ns/1ps
`default_nettype none

module mio_drive_model #(
   parameter int N_AXES = 8
) (
   input wire logic [N_AXES*7-1:0] pins_i,
   input wire logic [3:0] code_i,
   input wire logic [N_AXES*16-1:0] extra_i,
   output logic [N_AXES*16-1:0] pts_o
);
   function automatic logic lim(input logic [3:0] c, input logic [6:0] p);
      return c < 7 ? p[c[2:0]] : c == 7 ? 1'b1 : c == 8 ? 1'b0 : ~p[3'(c - 9)];
   endfunction : lim

   function automatic logic lat(input logic [3:0] c, input logic [6:0] p);
      return (c >= 4 && c <= 6) ? ~p[c[2:0]] : c == 7 ? 1'b1 : c >= 13 ? p[3'(c - 9)] : 1'b0;
   endfunction : lat

   // Unselected signals follow extra_i; a real drive picks pins by its own setting
   always_comb begin
      pts_o = extra_i;
      for (int g = 0; g < N_AXES; g++) begin
         pts_o[g*16] = lim(code_i, pins_i[g*7+:7]);
         pts_o[g*16+1] = lim(~code_i, pins_i[g*7+:7]);
         pts_o[g*16+2] = lim(code_i ^ 4'h5, pins_i[g*7+:7]);
         pts_o[g*16+6] = lat(code_i, pins_i[g*7+:7]);
         pts_o[g*16+9] = (code_i != 0 && code_i <= 3) ? pins_i[g*7+code_i] : 1'b0;
      end
   end
endmodule : mio_drive_model

`default_nettype wire

// [bench/mio_top_properties.sv]
/*
 * Concurrent checks on the mio_top ports: bus timing, front lines and
 * drive images. Assumes a single clock domain with synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module mio_top_checker
   import mio_pkg::*;
#(
   parameter int N_AXES = 8,
   parameter int AXIS_W = 3
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [WORD_BITS-1:0] pwdata_i,
   input wire logic [WORD_BITS-1:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [PHYS_IN_BITS-1:0] front_in_i,
   input wire logic [PHYS_OUT_BITS-1:0] front_out_o,
   input wire logic [N_AXES*DRIVE_PTS-1:0] drive_pts_i,
   input wire logic [N_AXES*DRIVE_PTS-1:0] drive_pts_o
);
   logic [WORD_BITS-1:0] inv_q;
   // Completed transfers and a few named slices
   wire logic rd = pready_o && !pwrite_i;
   wire logic wr = pready_o && pwrite_i && psel_i && penable_i;
   wire logic [7:0] wd_front = pwdata_i[15:8];
   wire logic [15:0] inv_hi = inv_q[31:16];

   // Shadow of the invert word, needed to predict reads and images
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) inv_q <= WORD_ZERO;
      else if (wr && paddr_i == OFS_INVERT) inv_q <= pwdata_i;
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_setup; psel_i && !penable_i; endsequence
   sequence s_answer; !pready_o ##1 pready_o; endsequence

   a_ready_timing: assert property (s_setup |=> s_answer)
      else $error("ready not in second access cycle");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_noline_zero: assert property (rd && paddr_i == OFS_OUT_BASE |-> prdata_o[7:0] == 8'h00)
      else $error("absent outputs read nonzero");
   a_front_readback: assert property (rd && paddr_i == OFS_OUT_BASE |-> prdata_o[15:8] == front_out_o)
      else $error("front outputs read wrong");
   a_front_write: assert property (wr && paddr_i == OFS_OUT_BASE |=> front_out_o == $past(wd_front))
      else $error("front outputs not written");
   a_front_hold: assert property (!$stable(front_out_o) |-> $past(wr) && $past(paddr_i) == OFS_OUT_BASE)
      else $error("front outputs moved without a write");
   a_front_in_read: assert property (rd && paddr_i == OFS_IN_BASE && $past(front_in_i, 2) == front_in_i
      |-> prdata_o[15:0] == (front_in_i ^ inv_q[15:0]))
      else $error("front inputs read wrong");
   a_err_flag: assert property (pready_o && (paddr_i > OFS_DRIVE_CFG || paddr_i[1:0] != 2'b00)
      |-> pslverr_o && prdata_o == WORD_ZERO)
      else $error("unmapped access not refused");
   a_drive_image: assert property ((drive_pts_o & ~($past(drive_pts_i) ^ {N_AXES{$past(inv_hi)}})) == '0)
      else $error("drive image bit without cause");
endmodule : mio_top_checker

bind mio_top mio_top_checker #(.N_AXES(N_AXES), .AXIS_W(AXIS_W)) u_chk (.ref_clk_i, .rst_n_i, .paddr_i,
   .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .front_in_i, .front_out_o,
   .drive_pts_i, .drive_pts_o);

`default_nettype wire

// [bench/testbench.sv]
/*
 * Self-checking bench for mio_top with a point-space model and drives.
 * Assumes a 40 MHz clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import mio_pkg::*;
   localparam int NA = 8;
   localparam int PW = NA * 7;
   localparam int DW = NA * 16;
   logic ref_clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, rdy, err, e;
   logic [ADDR_W-1:0] pad = '0;
   logic [31:0] pwd = '0, prd, r, inv = '0;
   logic [15:0] fin = '0;
   logic [7:0] fout;
   logic [PW-1:0] pins = '0;
   logic [3:0] code = '0;
   logic [DW-1:0] extra = '0, dpi, dpo;
   logic [31:0] outw [8], inw [8];
   logic [15:0] mtab [4];
   logic att [NA];
   logic [1:0] typ [NA];
   int n_fail = 0, samples_checked = 0;

   always #12.5 ref_clk_i = ~ref_clk_i;

   mio_top #(.N_AXES(NA), .AXIS_W(3)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .paddr_i(pad),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
      .pslverr_o(err), .front_in_i(fin), .front_out_o(fout), .drive_pts_i(dpi), .drive_pts_o(dpo));
   mio_drive_model #(.N_AXES(NA)) drv (.pins_i(pins), .code_i(code), .extra_i(extra), .pts_o(dpi));

   task automatic results;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask : chk

   // One APB transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk_i);
      psel <= 1;
      pwr <= w;
      pad <= a;
      pwd <= d;
      @(posedge ref_clk_i);
      pen <= 1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         results();
      end
      r = prd;
      e = err;
      psel <= 0;
      pen <= 0;
   endtask : apb

   // Expected image of one axis from what the drive presents
   function automatic logic [15:0] img(input int g);
      return att[g] ? ((dpi[g*16+:16] ^ inv[31:16]) & mtab[typ[g]]) : 16'h0000;
   endfunction : img

   initial begin
      int w;
      int g;
      logic [31:0] d;
      void'($urandom(32'h5592_f5da));
      mtab = '{USED_TYPE_A, USED_TYPE_B, USED_TYPE_C, USED_TYPE_D};
      for (int i = 0; i < NA; i++) begin
         att[i] = 0;
         typ[i] = 0;
         outw[i] = 0;
         inw[i] = 0;
      end
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1;
      apb(0, OFS_IN_BASE, 0);
      chk("in word after reset", r, 32'h0000_0000);
      // Fill every word twice, in two passes; invert set half way
      for (int k = 0; k < 16; k++) begin
         w = k % 8;
         d = $urandom;
         apb(1, 12'(w * 4), d);
         outw[w] = d;
         apb(1, OFS_IN_BASE + 12'(w * 4), ~d);
         inw[w] = ~d;
         if (k == 8) begin
            apb(1, OFS_INVERT, d);
            inv = d;
         end
      end
      fin <= 16'($urandom);
      pins <= PW'({$urandom, $urandom});
      extra <= DW'({$urandom, $urandom, $urandom, $urandom});
      for (w = 0; w < 8; w++) begin
         apb(0, 12'(w * 4), 0);
         chk("out word", r, w == 0 ? {outw[0][31:16], outw[0][15:8], 8'h00} : outw[w]);
         apb(0, OFS_IN_BASE + 12'(w * 4), 0);
         chk("in word", r, w == 0 ? ({inw[0][31:16], fin} ^ inv) : inw[w]);
      end
      chk("front out", 32'(fout), 32'(outw[0][15:8]));
      // Every selector code, every axis, every drive type, one detached axis
      for (int it = 0; it < 16; it++) begin
         g = it % NA;
         code <= 4'(it);
         pins <= PW'({$urandom, $urandom});
         apb(1, OFS_AXIS_SEL, 32'(g));
         att[g] = (g != 5);
         typ[g] = 2'(it + it / 8);
         apb(1, OFS_DRIVE_CFG, {29'h0, typ[g], att[g]});
         apb(0, OFS_DRIVE_IN, 0);
         chk("drive in", r, {img(g), 16'h0000});
         for (int a = 0; a < NA; a++) chk("drive out", 32'(dpo[a*16+:16]), 32'(img(a)));
      end
      apb(0, 12'h100, 0);
      chk("unmapped read", {e, r[30:0]}, 32'h8000_0000);
      apb(1, 12'h002, 32'hFFFF_FFFF);
      chk("unaligned write", 32'(e), 32'h0000_0001);
      apb(0, OFS_OUT_BASE, 0);
      chk("out word kept", r, {outw[0][31:16], outw[0][15:8], 8'h00});
      results();
   end
endmodule : testbench

`default_nettype wire

// [hw/mio_mem_if.sv]
/*
 * Carrier between the point-space top and its word store.
 * Assumes both ends share the top's clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface mio_mem_if;
   import mio_pkg::*;

   logic [MEM_AW-1:0] addr;
   logic we;
   logic [WORD_BITS-1:0] wdata;
   logic [WORD_BITS-1:0] rdata;

   modport user (output addr, output we, output wdata, input rdata);
   modport store (input addr, input we, input wdata, output rdata);
endinterface : mio_mem_if

`default_nettype wire

// [hw/mio_pkg.sv]
/*
 * Constants for the motion unit digital point space: register offsets,
 * point ranges, drive type codes and per-type masks of wired positions.
 * Assumes a 32-bit APB register bus with word-aligned byte addresses.
 */
package mio_pkg;

   // Point space
   localparam int POINT_COUNT = 256;
   localparam int WORD_BITS = 32;
   localparam int WORDS_PER_SPACE = POINT_COUNT / WORD_BITS;
   localparam int NOLINE_OUT_BITS = 8;
   localparam int PHYS_OUT_LSB = 8;
   localparam int PHYS_OUT_BITS = 8;
   localparam int PHYS_IN_BITS = 16;
   localparam int DRIVE_PTS = 16;
   localparam int DRIVE_LSB = 16;

   // APB address layout, byte addresses
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_OUT_BASE = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_IN_BASE = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_INVERT = 12'h040;
   localparam logic [ADDR_W-1:0] OFS_AXIS_SEL = 12'h044;
   localparam logic [ADDR_W-1:0] OFS_DRIVE_IN = 12'h048;
   localparam logic [ADDR_W-1:0] OFS_DRIVE_CFG = 12'h04C;
   localparam logic [ADDR_W-1:0] SPACE_MASK = 12'hFE0;
   localparam int MEM_AW = 4;

   // Drive configuration word fields
   localparam int CFG_ATTACH_BIT = 0;
   localparam int CFG_TYPE_LSB = 1;
   localparam int CFG_TYPE_W = 2;

   // Fixed values
   localparam logic [WORD_BITS-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [DRIVE_PTS-1:0] PTS_ZERO = 16'h0000;

   // Drive families and the mapped positions 16..31 each one wires
   typedef enum logic [1:0] {
      MIO_DRV_TYPE_A = 2'b00,
      MIO_DRV_TYPE_B = 2'b01,
      MIO_DRV_TYPE_C = 2'b10,
      MIO_DRV_TYPE_D = 2'b11
   } mio_drv_type_e;

   localparam logic [DRIVE_PTS-1:0] USED_TYPE_A = 16'hF3FF;
   localparam logic [DRIVE_PTS-1:0] USED_TYPE_B = 16'hF7FF;
   localparam logic [DRIVE_PTS-1:0] USED_TYPE_C = 16'h0647;
   localparam logic [DRIVE_PTS-1:0] USED_TYPE_D = 16'hFFE7;

   // Bus transfer sequencer, Gray coded along idle, fetch, done
   typedef enum logic [1:0] {
      MIO_ST_IDLE = 2'b00,
      MIO_ST_FETCH = 2'b01,
      MIO_ST_DONE = 2'b11
   } mio_state_e;

endpackage : mio_pkg

// [hw/mio_top.sv]
/*
 * Digital point space of a motion control unit behind an APB slave:
 * 256 outputs, 256 inputs, front lines, and per-axis drive input images.
 * Assumes APB3 timing, inputs synchronous to ref_clk_i, and drives that
 * already route and decode their own connector pins.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Provide 256 input points and 256 output points indexed from zero.
// - Outputs 0 to 7 ignore writes and always read zero.
// - Outputs 8 to 15 drive front lines; read returns commanded state.
// - Outputs 16 to 255 are stored bits that read back what was written.
// - Each output point exists once for the unit, never per axis.
// - Inputs 0 to 15 read the present state of the front lines.
// - Inputs 16 to 255 are stored software inputs readable by the host.
// - General input read returns one unit-wide value per point.
// - General read excludes drive inputs; they have their own read register.
// - Only network-attached drives have their inputs mapped.
// - Drive positions 16 and 17 carry forward and reverse overtravel.
// - Drive position 18 carries the homing slowdown switch.
// - Drive positions 19 to 21 carry encoder phases A, B and Z.
// - Drive positions 22 to 24 carry the three latch triggers.
// - Positions 25, 26 brake and stop; 28 to 31 general or clamp inputs.
// - Drive inputs are held separately for every axis.
// - Inverting a point affects unit input and every axis drive input.
module mio_top
   import mio_pkg::*;
#(
   parameter int N_AXES = 8,
   parameter int AXIS_W = 3
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [WORD_BITS-1:0] pwdata_i,
   output logic [WORD_BITS-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [PHYS_IN_BITS-1:0] front_in_i,
   output logic [PHYS_OUT_BITS-1:0] front_out_o,
   input wire logic [N_AXES*DRIVE_PTS-1:0] drive_pts_i,
   output logic [N_AXES*DRIVE_PTS-1:0] drive_pts_o
);

   // Image bit of each mapped drive point; bit 0 of an image is point 16.
   // Kept as names so the family masks below read as a wiring table.
   // A point moved here moves in every family at once, which is the
   // intent: the position of a signal does not depend on the family.
   localparam int BIT_FWD_OVERTRAVEL = 0;
   localparam int BIT_REV_OVERTRAVEL = 1;
   localparam int BIT_HOME_SLOWDOWN = 2;
   localparam int BIT_PHASE_A = 3;
   localparam int BIT_PHASE_B = 4;
   localparam int BIT_INDEX_Z = 5;
   localparam int BIT_LATCH_ONE = 6;
   localparam int BIT_LATCH_TWO = 7;
   localparam int BIT_LATCH_THREE = 8;
   localparam int BIT_BRAKE = 9;
   localparam int BIT_HALT = 10;
   localparam int BIT_GENERAL_2 = 11;
   localparam int BIT_GENERAL_LSB = 12;
   localparam int GENERAL_HIGH_W = 4;

   // Single image bit, the seed of every group but the high general inputs
   localparam logic [DRIVE_PTS-1:0] PT_ONE = 16'h0001;

   // Groups of points that families wire or leave out together
   localparam logic [DRIVE_PTS-1:0] GRP_LIMITS =
      (PT_ONE << BIT_FWD_OVERTRAVEL) | (PT_ONE << BIT_REV_OVERTRAVEL) | (PT_ONE << BIT_HOME_SLOWDOWN);
   localparam logic [DRIVE_PTS-1:0] GRP_PHASE_AB =
      (PT_ONE << BIT_PHASE_A) | (PT_ONE << BIT_PHASE_B);
   localparam logic [DRIVE_PTS-1:0] GRP_INDEX = PT_ONE << BIT_INDEX_Z;
   localparam logic [DRIVE_PTS-1:0] GRP_LATCH_ONE = PT_ONE << BIT_LATCH_ONE;
   localparam logic [DRIVE_PTS-1:0] GRP_LATCH_MORE =
      (PT_ONE << BIT_LATCH_TWO) | (PT_ONE << BIT_LATCH_THREE);
   localparam logic [DRIVE_PTS-1:0] GRP_BRAKE = PT_ONE << BIT_BRAKE;
   localparam logic [DRIVE_PTS-1:0] GRP_HALT = PT_ONE << BIT_HALT;
   localparam logic [DRIVE_PTS-1:0] GRP_GENERAL_2 = PT_ONE << BIT_GENERAL_2;
   localparam logic [DRIVE_PTS-1:0] GRP_GENERAL_HIGH =
      DRIVE_PTS'({GENERAL_HIGH_W{1'b1}}) << BIT_GENERAL_LSB;

   // Family wiring. The first family lacks the stop and general input 2,
   // the second adds the stop, the third wires only limits, first latch,
   // brake and stop, the fourth everything but the A and B phases.
   // Built from groups rather than copied hex, so a slip in one place
   // shows up as a mismatch against the bench's own table.
   localparam logic [DRIVE_PTS-1:0] FAM_A_PTS =
      GRP_LIMITS | GRP_PHASE_AB | GRP_INDEX | GRP_LATCH_ONE | GRP_LATCH_MORE | GRP_BRAKE | GRP_GENERAL_HIGH;
   localparam logic [DRIVE_PTS-1:0] FAM_B_PTS = FAM_A_PTS | GRP_HALT;
   localparam logic [DRIVE_PTS-1:0] FAM_C_PTS = GRP_LIMITS | GRP_LATCH_ONE | GRP_BRAKE | GRP_HALT;
   localparam logic [DRIVE_PTS-1:0] FAM_D_PTS =
      GRP_LIMITS | GRP_INDEX | GRP_LATCH_ONE | GRP_LATCH_MORE | GRP_BRAKE | GRP_HALT | GRP_GENERAL_2
      | GRP_GENERAL_HIGH;

   // Positions a drive family actually wires; the rest are forced low
   // Unknown codes fall back to the first family rather than to zero,
   // so a miscoded axis still shows its limits
   function automatic logic [DRIVE_PTS-1:0] used_mask(input logic [CFG_TYPE_W-1:0] kind);
      logic [DRIVE_PTS-1:0] m;
      m = FAM_A_PTS;
      case (mio_drv_type_e'(kind))
         MIO_DRV_TYPE_A: m = FAM_A_PTS;
         MIO_DRV_TYPE_B: m = FAM_B_PTS;
         MIO_DRV_TYPE_C: m = FAM_C_PTS;
         MIO_DRV_TYPE_D: m = FAM_D_PTS;
         default: m = FAM_A_PTS;
      endcase
      return m;
   endfunction : used_mask

   // True when an address falls inside one of the two point spaces
   function automatic logic in_space(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
      return (a & SPACE_MASK) == base;
   endfunction : in_space

   // Two eight-word spaces of 32 points each give the 256 outputs and
   // 256 inputs; the store is one array so both share a single read port
   mio_mem_if mem_bus ();

   mio_word_mem u_store (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .mem(mem_bus.store)
   );

   mio_state_e state;
   mio_state_e next_state;
   logic [WORD_BITS-1:0] invert;
   logic [AXIS_W-1:0] axis_sel;
   logic [N_AXES-1:0] attached;
   logic [CFG_TYPE_W-1:0] drv_kind [0:N_AXES-1];
   logic [DRIVE_PTS-1:0] drv_img [0:N_AXES-1];

   // Address decode of the held request.
   // The request stands unchanged from setup to the ready edge, so the
   // decode needs no register of its own and stays valid in every state.
   // Misaligned addresses still hit a space but are refused below.
   wire logic hit_out = in_space(paddr_i, OFS_OUT_BASE);
   wire logic hit_in = in_space(paddr_i, OFS_IN_BASE);
   wire logic hit_inv = (paddr_i == OFS_INVERT);
   wire logic hit_sel = (paddr_i == OFS_AXIS_SEL);
   wire logic hit_din = (paddr_i == OFS_DRIVE_IN);
   wire logic hit_cfg = (paddr_i == OFS_DRIVE_CFG);
   wire logic aligned = (paddr_i[1:0] == 2'b00);
   wire logic hit_any = aligned & (hit_out | hit_in | hit_inv | hit_sel | hit_din | hit_cfg);
   wire logic word0 = (paddr_i[4:2] == 3'b000);
   wire logic axis_ok = (32'(axis_sel) < N_AXES);

   // A write takes effect only at the edge that ends the access phase
   wire logic commit = (state == MIO_ST_DONE) & psel_i & penable_i;
   wire logic wr_commit = commit & pwrite_i & hit_any;

   // Store index: bit 3 selects the input space, low bits the word
   assign mem_bus.addr = {hit_in, paddr_i[4:2]};
   assign mem_bus.we = wr_commit & (hit_out | hit_in);
   assign mem_bus.wdata = pwdata_i;

   // Transfer sequencer: setup addresses the store, fetch forms the answer.
   // Walk: setup edge enters fetch; the store's read data lands at that
   // edge, so fetch can register the answer; done is the ready cycle.
   // The fixed two-cycle access trades speed for a registered read path.
   // Done always returns to idle, so a back-to-back setup is taken one
   // edge later, which is exactly when the master shows it.
   always_comb begin
      next_state = state;
      case (state)
         MIO_ST_IDLE: begin
            if (psel_i & ~penable_i) begin
               next_state = MIO_ST_FETCH;
            end
         end
         MIO_ST_FETCH: begin
            next_state = MIO_ST_DONE;
         end
         MIO_ST_DONE: begin
            next_state = MIO_ST_IDLE;
         end
         default: begin
            next_state = MIO_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state <= MIO_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Output word 0: no-line bits zero, front lines from their flops
   wire logic [WORD_BITS-1:0] out_word0 =
      {mem_bus.rdata[WORD_BITS-1:PHYS_OUT_LSB+PHYS_OUT_BITS], front_out_o,
       {NOLINE_OUT_BITS{1'b0}}};

   // Input word 0: front lines below, stored software points above
   wire logic [WORD_BITS-1:0] in_word0 =
      {mem_bus.rdata[WORD_BITS-1:PHYS_IN_BITS], front_in_i} ^ invert;

   // Unit-wide read of a point word; drive images never appear here
   wire logic [WORD_BITS-1:0] out_word = word0 ? out_word0 : mem_bus.rdata;
   wire logic [WORD_BITS-1:0] in_word = word0 ? in_word0 : mem_bus.rdata;

   wire logic [DRIVE_PTS-1:0] sel_img = axis_ok ? drv_img[axis_sel] : PTS_ZERO;
   wire logic sel_attached = axis_ok ? attached[axis_sel] : 1'b0;
   wire logic [CFG_TYPE_W-1:0] sel_kind = axis_ok ? drv_kind[axis_sel] : 2'b00;

   wire logic [WORD_BITS-1:0] cfg_word =
      WORD_ZERO | (WORD_BITS'(sel_kind) << CFG_TYPE_LSB) | WORD_BITS'(sel_attached);

   // Read data selection for the held address
   logic [WORD_BITS-1:0] rd_word;
   always_comb begin
      rd_word = WORD_ZERO;
      if (hit_out) begin
         rd_word = out_word;
      end else if (hit_in) begin
         rd_word = in_word;
      end else if (hit_inv) begin
         rd_word = invert;
      end else if (hit_sel) begin
         rd_word = WORD_BITS'(axis_sel);
      end else if (hit_din) begin
         rd_word = {sel_img, PTS_ZERO};
      end else if (hit_cfg) begin
         rd_word = cfg_word;
      end
   end

   // Answer flops: ready and error rise for the cycle of the sampling edge.
   // Read data is loaded only in fetch and then held, so it stays steady
   // through the ready cycle; writes and refused reads return zero.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= WORD_ZERO;
      end else begin
         pready_o <= (next_state == MIO_ST_DONE);
         pslverr_o <= (next_state == MIO_ST_DONE) & ~hit_any;
         if (state == MIO_ST_FETCH) begin
            prdata_o <= (hit_any & ~pwrite_i) ? rd_word : WORD_ZERO;
         end
      end
   end

   // Front output lines: only bits 8..15 of output word 0 reach them
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         front_out_o <= '0;
      end else if (wr_commit & hit_out & word0) begin
         front_out_o <= pwdata_i[PHYS_OUT_LSB +: PHYS_OUT_BITS];
      end
   end

   // Polarity inversion of points 0..31; also steers every axis image
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         invert <= WORD_ZERO;
      end else if (wr_commit & hit_inv) begin
         invert <= pwdata_i;
      end
   end

   // Axis selector for the drive input and configuration windows
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         axis_sel <= '0;
      end else if (wr_commit & hit_sel) begin
         axis_sel <= pwdata_i[AXIS_W-1:0];
      end
   end

   // Per-axis drive attachment and family; writes to a missing axis are dropped.
   // Detached axes keep their family code, so reattaching needs one write.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         attached <= '0;
         for (int i = 0; i < N_AXES; i++) begin
            drv_kind[i] <= 2'b00;
         end
      end else if (wr_commit & hit_cfg & axis_ok) begin
         attached[axis_sel] <= pwdata_i[CFG_ATTACH_BIT];
         drv_kind[axis_sel] <= pwdata_i[CFG_TYPE_LSB +: CFG_TYPE_W];
      end
   end

   // Drive images: each axis keeps its own positions 16..31.
   // One register stage per axis; a drive input shows on the image one
   // cycle after it arrives, and the read window adds the bus latency.
   for (genvar g = 0; g < N_AXES; g++) begin : g_axis
      // Positions arrive already decoded by the drive's own pin selectors
      wire logic [DRIVE_PTS-1:0] raw = drive_pts_i[g*DRIVE_PTS +: DRIVE_PTS];
      // Inversion first, then the mask, so an inverted unused point stays low
      wire logic [DRIVE_PTS-1:0] shaped =
         (raw ^ invert[DRIVE_LSB +: DRIVE_PTS]) & used_mask(drv_kind[g]);

      always_ff @(posedge ref_clk_i) begin
         if (!rst_n_i) begin
            drv_img[g] <= PTS_ZERO;
         end else begin
            // Positions 16..31 map in bit order: limits, slowdown, phases,
            // latches, brake, stop, general or clamp inputs
            drv_img[g] <= attached[g] ? shaped : PTS_ZERO;
         end
      end

      assign drive_pts_o[g*DRIVE_PTS +: DRIVE_PTS] = drv_img[g];
   end

   // Limitation: active-low signals of one family arrive as delivered.
   // Software flips them with the inversion word, which then also flips
   // the unit-wide input of the same number on every axis.

endmodule : mio_top

`default_nettype wire

// [hw/mio_word_mem.sv]
/*
 * Word store for the software points: output words then input words.
 * Assumes synchronous active-low reset; read data is registered, one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module mio_word_mem
   import mio_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   mio_mem_if.store mem
);

   logic [WORD_BITS-1:0] words [0:(1 << MEM_AW)-1];

   // Cleared on reset so every stored point reads zero until written
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < (1 << MEM_AW); i++) begin
            words[i] <= WORD_ZERO;
         end
         mem.rdata <= WORD_ZERO;
      end else begin
         if (mem.we) begin
            words[mem.addr] <= mem.wdata;
         end
         mem.rdata <= words[mem.addr];
      end
   end

endmodule : mio_word_mem

`default_nettype wire
